// ===== verilog/orc_ctrl.sv
// orc_ctrl: output routing, frame grouping and run-length reload control
// assumes classic wishbone master, sources and strobes on clk_i
//
// Function
// - output 2 selector bits 8..6
// - output 3 selector bits 11..9
// - output 4 selector bits 14..12
// - output 5 selector bits 17..15
// - output 6 selector bits 20..18
// - code zero drives host-written output bit
// - code 101b drives internal clock
// - code 110b drives internal waveform
// - bits 22..21 pick 1/16/128/1024 frames per group
// - one dma frame done per frame group
// - horizontal counter loads bits 27..24 on line enable
// - horizontal reload is entry index, not address
// - vertical counter loads bits 31..28 on frame enable
// - vertical reload is entry index, not address
`timescale 1ns/100ps
module orc_ctrl
    import orc_pkg::*;
(
    input wire logic clk_i,                 // 250 MHz clock
    input wire logic rst_i,                 // sync reset, high
    input wire logic ce_i,                  // clock enable, freezes state
    input wire logic wb_cyc_i,              // wishbone cycle
    input wire logic wb_stb_i,              // wishbone strobe
    input wire logic wb_we_i,               // wishbone write
    input wire logic [ORC_AW-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i,        // byte enables
    input wire logic [ORC_DW-1:0] wb_dat_i, // write data
    output logic [ORC_DW-1:0] wb_dat_o,     // read data
    output logic wb_ack_o,                  // acknowledge
    input wire logic [3:0] table_output_i,  // control table outputs 0..3
    input wire logic int_clock_i,           // internal generated clock
    input wire logic waveform_i,            // internal generated waveform
    input wire logic camera_frame_i,        // camera frame done pulse
    input wire logic line_enable_i,         // line enable strobe
    input wire logic frame_enable_i,        // frame enable strobe
    input wire logic h_advance_i,           // horizontal entry step
    input wire logic v_advance_i,           // vertical entry step
    output logic [ORC_NOUT-1:0] general_output_o, // outputs 2..6
    output logic dma_frame_done_o,          // one pulse per frame group
    output logic [3:0] h_entry_o,           // horizontal run-length entry
    output logic [3:0] v_entry_o            // vertical run-length entry
);
    logic [31:0] ctrl_q;
    logic [ORC_NOUT-1:0] host_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [9:0] gcnt_q;
    logic dma_q;
    logic [3:0] h_q;
    logic [3:0] v_q;
    logic req;
    logic wr_go;
    logic [31:0] bmask;
    logic [31:0] rd_mux;
    logic [10:0] grp_n;
    logic grp_last;

    orc_route_if rif ();

    assign req = wb_cyc_i && wb_stb_i;
    assign wr_go = req && wb_we_i && ack_q;
    assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // one-wait-state ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req && !ack_q;
        end
    end

    // writes land at the edge where ack is sampled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= ORC_CTRL_RST;
        end else if (ce_i && wr_go && wb_adr_i == ORC_ADDR_CTRL) begin
            ctrl_q <= (ctrl_q & ~(bmask & ORC_CTRL_WMASK))
                | (wb_dat_i & bmask & ORC_CTRL_WMASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_q <= ORC_HOST_RST;
        end else if (ce_i && wr_go && wb_adr_i == ORC_ADDR_HOST && wb_sel_i[0]) begin
            host_q <= wb_dat_i[ORC_HOST_LSB +: ORC_NOUT];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            ORC_ADDR_CTRL: rd_mux = ctrl_q;
            ORC_ADDR_HOST: rd_mux[ORC_HOST_LSB +: ORC_NOUT] = host_q;
            ORC_ADDR_STAT: begin
                rd_mux[ORC_ST_H_LSB +: 4] = h_q;
                rd_mux[ORC_ST_V_LSB +: 4] = v_q;
                rd_mux[ORC_ST_G_LSB +: 10] = gcnt_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (ce_i && req && !ack_q) begin
            rdat_q <= rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // selector fields into the mux carrier
    assign rif.sel = {ctrl_q[ORC_OUT6_LSB +: ORC_SELW],
                      ctrl_q[ORC_OUT5_LSB +: ORC_SELW],
                      ctrl_q[ORC_OUT4_LSB +: ORC_SELW],
                      ctrl_q[ORC_OUT3_LSB +: ORC_SELW],
                      ctrl_q[ORC_OUT2_LSB +: ORC_SELW]};
    assign rif.host = host_q;
    assign rif.tab = table_output_i;
    assign rif.int_clk = int_clock_i;
    assign rif.wave = waveform_i;

    // reserved code held low inside each mux
    genvar gi;
    generate
        for (gi = 0; gi < ORC_NOUT; gi++) begin : g_out
            orc_out_mux #(
                .IDX(gi)
            ) u_mux (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .rif(rif),
                .out_o(general_output_o[gi])
            );
        end
    endgenerate

    // frame grouping
    always_comb begin
        case (ctrl_q[ORC_GRP_LSB +: 2])
            2'h0: grp_n = ORC_GRP_N0;
            2'h1: grp_n = ORC_GRP_N1;
            2'h2: grp_n = ORC_GRP_N2;
            2'h3: grp_n = ORC_GRP_N3;
            default: grp_n = ORC_GRP_N0;
        endcase
    end

    // also closes a group left over-long by a smaller setting
    assign grp_last = ({1'b0, gcnt_q} + 11'd1) >= grp_n;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gcnt_q <= ORC_GCNT_RST;
        end else if (ce_i && camera_frame_i) begin
            gcnt_q <= grp_last ? ORC_GCNT_RST : gcnt_q + 10'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_q <= 1'b0;
        end else if (ce_i) begin
            dma_q <= camera_frame_i && grp_last;
        end
    end

    assign dma_frame_done_o = dma_q;

    // run-length entry counters, reload has priority over step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_q <= ORC_RL_RST;
        end else if (ce_i) begin
            if (line_enable_i) begin
                h_q <= ctrl_q[ORC_HRL_LSB +: 4];
            end else if (h_advance_i) begin
                h_q <= h_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            v_q <= ORC_RL_RST;
        end else if (ce_i) begin
            if (frame_enable_i) begin
                v_q <= ctrl_q[ORC_VRL_LSB +: 4];
            end else if (v_advance_i) begin
                v_q <= v_q + 4'h1;
            end
        end
    end

    assign h_entry_o = h_q;
    assign v_entry_o = v_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_out2_tab0: assert property (
        ce_i && ctrl_q[ORC_OUT2_LSB +: 3] == 3'h1
        |=> general_output_o[0] == $past(table_output_i[0]))
        else $error("output 2 not following table output 0");

    a_out3_tab1: assert property (
        ce_i && ctrl_q[ORC_OUT3_LSB +: 3] == 3'h2
        |=> general_output_o[1] == $past(table_output_i[1]))
        else $error("output 3 not following table output 1");

    a_out4_tab2: assert property (
        ce_i && ctrl_q[ORC_OUT4_LSB +: 3] == 3'h3
        |=> general_output_o[2] == $past(table_output_i[2]))
        else $error("output 4 not following table output 2");

    a_out5_tab3: assert property (
        ce_i && ctrl_q[ORC_OUT5_LSB +: 3] == 3'h4
        |=> general_output_o[3] == $past(table_output_i[3]))
        else $error("output 5 not following table output 3");

    a_out6_host: assert property (
        ce_i && ctrl_q[ORC_OUT6_LSB +: 3] == 3'h0
        |=> general_output_o[4] == $past(host_q[4]))
        else $error("output 6 not following host bit");

    a_out2_host: assert property (
        ce_i && ctrl_q[ORC_OUT2_LSB +: 3] == 3'h0
        |=> general_output_o[0] == $past(host_q[0]))
        else $error("output 2 not following host bit");

    a_out3_clock: assert property (
        ce_i && ctrl_q[ORC_OUT3_LSB +: 3] == 3'h5
        |=> general_output_o[1] == $past(int_clock_i))
        else $error("output 3 not following internal clock");

    a_out4_wave: assert property (
        ce_i && ctrl_q[ORC_OUT4_LSB +: 3] == 3'h6
        |=> general_output_o[2] == $past(waveform_i))
        else $error("output 4 not following waveform");

    a_rsv_low: assert property (
        ce_i && ctrl_q[ORC_OUT5_LSB +: 3] == 3'h7 |=> !general_output_o[3])
        else $error("reserved code did not hold output low");

    a_rsv_bit_zero: assert property (
        !ctrl_q[ORC_RSV_BIT])
        else $error("reserved control bit set");

    a_group_single: assert property (
        ce_i && camera_frame_i && ctrl_q[ORC_GRP_LSB +: 2] == 2'h0
        |=> dma_frame_done_o)
        else $error("single frame group did not complete");

    a_group_first_held: assert property (
        ce_i && camera_frame_i && gcnt_q == 10'd0
        && ctrl_q[ORC_GRP_LSB +: 2] != 2'h0 |=> !dma_frame_done_o)
        else $error("group completed on its first frame");

    a_group_sixteen: assert property (
        ce_i && camera_frame_i && gcnt_q == 10'd15
        && ctrl_q[ORC_GRP_LSB +: 2] == 2'h1
        |=> dma_frame_done_o && gcnt_q == 10'd0)
        else $error("sixteen frame group not closed");

    a_dma_cause: assert property (
        dma_frame_done_o |-> $past(camera_frame_i) && $past(ce_i))
        else $error("dma frame done without a camera frame");

    a_h_reload: assert property (
        ce_i && line_enable_i |=> h_entry_o == $past(ctrl_q[ORC_HRL_LSB +: 4]))
        else $error("horizontal counter missed reload");

    a_v_reload: assert property (
        ce_i && frame_enable_i |=> v_entry_o == $past(ctrl_q[ORC_VRL_LSB +: 4]))
        else $error("vertical counter missed reload");

    a_freeze_hold: assert property (
        !ce_i |=> $stable(h_entry_o) && $stable(gcnt_q) && $stable(ctrl_q))
        else $error("state moved with clock enable low");

    a_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged after one wait state");

    a_ack_idle: assert property (
        ce_i && !wb_stb_i |=> !wb_ack_o)
        else $error("ack without a strobe");

    a_ctrl_write: assert property (
        ce_i && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i == 4'hF
        && wb_adr_i == ORC_ADDR_CTRL |=> ctrl_q == ($past(wb_dat_i) & ORC_CTRL_WMASK))
        else $error("control write did not land masked");

    a_host_write: assert property (
        ce_i && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && wb_adr_i == ORC_ADDR_HOST
        |=> host_q == $past(wb_dat_i[ORC_HOST_LSB +: ORC_NOUT]))
        else $error("host bit write did not land");

    a_out6_tab0: assert property (
        ce_i && ctrl_q[ORC_OUT6_LSB +: 3] == 3'h1
        |=> general_output_o[4] == $past(table_output_i[0]))
        else $error("output 6 not following table output 0");

    a_out5_clock: assert property (
        ce_i && ctrl_q[ORC_OUT5_LSB +: 3] == 3'h5
        |=> general_output_o[3] == $past(int_clock_i))
        else $error("output 5 not following internal clock");

    a_out6_wave: assert property (
        ce_i && ctrl_q[ORC_OUT6_LSB +: 3] == 3'h6
        |=> general_output_o[4] == $past(waveform_i))
        else $error("output 6 not following waveform");

    a_out2_rsv: assert property (
        ce_i && ctrl_q[ORC_OUT2_LSB +: 3] == 3'h7 |=> !general_output_o[0])
        else $error("reserved code did not hold output 2 low");

    a_group_128: assert property (
        ce_i && camera_frame_i && gcnt_q == 10'd127
        && ctrl_q[ORC_GRP_LSB +: 2] == 2'h2
        |=> dma_frame_done_o && gcnt_q == 10'd0)
        else $error("128 frame group not closed");

    a_group_1024: assert property (
        ce_i && camera_frame_i && gcnt_q == 10'd1023
        && ctrl_q[ORC_GRP_LSB +: 2] == 2'h3
        |=> dma_frame_done_o && gcnt_q == 10'd0)
        else $error("1024 frame group not closed");

    a_group_wait: assert property (
        ce_i && camera_frame_i && gcnt_q != 10'd1023
        && ctrl_q[ORC_GRP_LSB +: 2] == 2'h3 |=> !dma_frame_done_o)
        else $error("1024 frame group closed early");

    a_h_step: assert property (
        ce_i && !line_enable_i && h_advance_i
        |=> h_entry_o == $past(h_entry_o) + 4'h1)
        else $error("horizontal entry did not step");

    a_v_step: assert property (
        ce_i && !frame_enable_i && v_advance_i
        |=> v_entry_o == $past(v_entry_o) + 4'h1)
        else $error("vertical entry did not step");

    c_group_done: cover property (
        ctrl_q[ORC_GRP_LSB +: 2] == 2'h1 && dma_frame_done_o);
    c_out_clock: cover property (
        ctrl_q[ORC_OUT2_LSB +: 3] == 3'h5 && general_output_o[0]);
    c_h_reload: cover property (
        line_enable_i && ctrl_q[ORC_HRL_LSB +: 4] == 4'h3);
    c_bus_write: cover property (
        wb_ack_o && wb_we_i && wb_adr_i == ORC_ADDR_CTRL);
endmodule

// ===== verilog/orc_pkg.sv
// orc_pkg: constants, field layout and source codes for output routing
// assumes a 32-bit classic wishbone slave and one 250 MHz clock
package orc_pkg;
    localparam int unsigned ORC_DW = 32;
    localparam int unsigned ORC_AW = 8;
    localparam int unsigned ORC_NOUT = 5;
    localparam int unsigned ORC_SELW = 3;
    // byte offsets
    localparam logic [7:0] ORC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ORC_ADDR_HOST = 8'h04;
    localparam logic [7:0] ORC_ADDR_STAT = 8'h08;
    // control register fields
    localparam int unsigned ORC_OUT2_LSB = 6;
    localparam int unsigned ORC_OUT3_LSB = 9;
    localparam int unsigned ORC_OUT4_LSB = 12;
    localparam int unsigned ORC_OUT5_LSB = 15;
    localparam int unsigned ORC_OUT6_LSB = 18;
    localparam int unsigned ORC_GRP_LSB = 21;
    localparam int unsigned ORC_RSV_BIT = 23;
    localparam int unsigned ORC_HRL_LSB = 24;
    localparam int unsigned ORC_VRL_LSB = 28;
    localparam logic [31:0] ORC_CTRL_WMASK = 32'hFF7F_FFFF;
    localparam logic [31:0] ORC_CTRL_RST = 32'h0000_0000;
    // host bit register: bits 6..2 drive outputs 2..6
    localparam int unsigned ORC_HOST_LSB = 2;
    localparam logic [4:0] ORC_HOST_RST = 5'h00;
    // status register fields
    localparam int unsigned ORC_ST_H_LSB = 0;
    localparam int unsigned ORC_ST_V_LSB = 4;
    localparam int unsigned ORC_ST_G_LSB = 8;
    // frames per dma frame
    localparam logic [10:0] ORC_GRP_N0 = 11'd1;
    localparam logic [10:0] ORC_GRP_N1 = 11'd16;
    localparam logic [10:0] ORC_GRP_N2 = 11'd128;
    localparam logic [10:0] ORC_GRP_N3 = 11'd1024;
    localparam logic [3:0] ORC_RL_RST = 4'h0;
    localparam logic [9:0] ORC_GCNT_RST = 10'h000;

    typedef enum logic [2:0] {
        ORC_SRC_HOST = 3'b000,
        ORC_SRC_TAB0 = 3'b001,
        ORC_SRC_TAB1 = 3'b010,
        ORC_SRC_TAB2 = 3'b011,
        ORC_SRC_TAB3 = 3'b100,
        ORC_SRC_CLK = 3'b101,
        ORC_SRC_WAVE = 3'b110,
        ORC_SRC_RSV = 3'b111
    } orc_src_e;
endpackage

// ===== verilog/orc_route_if.sv
// orc_route_if: selectors and candidate sources for the output muxes
// assumes all sources are on the block clock
`timescale 1ns/100ps
interface orc_route_if;
    import orc_pkg::*;
    logic [ORC_NOUT*ORC_SELW-1:0] sel;
    logic [ORC_NOUT-1:0] host;
    logic [3:0] tab;
    logic int_clk;
    logic wave;
    modport src (output sel, output host, output tab, output int_clk, output wave);
    modport mux (input sel, input host, input tab, input int_clk, input wave);
endinterface

// ===== verilog/orc_out_mux.sv
// orc_out_mux: one registered output steered by a 3-bit selector
// assumes selectors and sources arrive on clk_i
`timescale 1ns/100ps
module orc_out_mux
    import orc_pkg::*;
#(
    parameter int unsigned IDX = 0
) (
    input wire logic clk_i,    // block clock
    input wire logic rst_i,    // sync reset, high
    input wire logic ce_i,     // clock enable
    orc_route_if.mux rif,      // selectors and sources
    output logic out_o         // steered output
);
    orc_src_e sel;
    logic pick;
    logic out_q;

    assign sel = orc_src_e'(rif.sel[IDX*ORC_SELW +: ORC_SELW]);

    always_comb begin
        case (sel)
            ORC_SRC_HOST: pick = rif.host[IDX];
            ORC_SRC_TAB0: pick = rif.tab[0];
            ORC_SRC_TAB1: pick = rif.tab[1];
            ORC_SRC_TAB2: pick = rif.tab[2];
            ORC_SRC_TAB3: pick = rif.tab[3];
            ORC_SRC_CLK: pick = rif.int_clk;
            ORC_SRC_WAVE: pick = rif.wave;
            default: pick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
        end else if (ce_i) begin
            out_q <= pick;
        end
    end

    assign out_o = out_q;
endmodule

// ===== testbench/orc_io_sink.sv
// orc_io_sink: equipment on the connector outputs, counts rises of output 2
// assumes connector levels are sampled on the block clock
`timescale 1ns/100ps
module orc_io_sink (
    input wire logic clk_i,        // sample clock
    input wire logic rst_i,        // sync reset, high
    input wire logic [4:0] pins_i, // connector outputs 2..6
    output logic [7:0] rises_o     // rises seen on output 2
);
    logic last_q;
    always_ff @(posedge clk_i) begin
        last_q <= pins_i[0];
        if (rst_i) begin
            rises_o <= 8'h0;
        end else if (pins_i[0] && !last_q) begin
            rises_o <= rises_o + 8'h1;
        end
    end
endmodule

// ===== testbench/test_output_steering_and_frame_grouping.sv
// test_output_steering_and_frame_grouping: self-checking bench for orc_ctrl
// assumes orc_pkg, orc_route_if, the design and orc_io_sink compiled first
`timescale 1ns/100ps
module test_output_steering_and_frame_grouping import orc_pkg::*; ;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, iclk = 1'h0, wave = 1'h0;
    logic cf = 1'h0, le = 1'h0, fe = 1'h0, ha = 1'h0, va = 1'h0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] tab = 4'h0;
    logic ce = 1'h1;
    logic [31:0] rdat, ctrl, rd;
    logic ack, dma;
    logic [4:0] gout, host;
    logic [3:0] h_ent, v_ent, h, v;
    logic [7:0] rises, r0;
    int fails = 0;
    int cmp_count = 0;
    int dma_seen = 0;
    int grp_n[4] = '{1, 16, 128, 1024};

    orc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .table_output_i(tab),
        .int_clock_i(iclk), .waveform_i(wave), .camera_frame_i(cf),
        .line_enable_i(le), .frame_enable_i(fe), .h_advance_i(ha),
        .v_advance_i(va), .general_output_o(gout), .dma_frame_done_o(dma),
        .h_entry_o(h_ent), .v_entry_o(v_ent));
    orc_io_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .pins_i(gout), .rises_o(rises));

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (dma === 1'h1) dma_seen <= dma_seen + 1;

    task close_out;
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_small(input logic [7:0] got, input logic [7:0] exp);
        chk_word({24'h0, got}, {24'h0, exp});
    endtask

    // one classic cycle; data taken at the edge that sees ack
    task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                 output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        if (n >= 20) fails++;
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask

    task wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'h1, a, d, q);
    endtask

    task frame;
        @(posedge clk_i) cf <= 1'h1;
        @(posedge clk_i) cf <= 1'h0;
    endtask

    function automatic logic [4:0] exp_outs(logic [31:0] c, logic [4:0] hb);
        logic [2:0] s;
        for (int k = 0; k < 5; k++) begin
            s = c[ORC_OUT2_LSB + 3 * k +: 3];
            case (s)
                3'h0: exp_outs[k] = hb[k];
                3'h1, 3'h2, 3'h3, 3'h4: exp_outs[k] = tab[s - 3'h1];
                3'h5: exp_outs[k] = iclk;
                3'h6: exp_outs[k] = wave;
                default: exp_outs[k] = 1'h0;
            endcase
        end
    endfunction

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        close_out();
    end

    initial begin
        void'($urandom(32'hF90C));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        wb_xfer(1'h0, ORC_ADDR_CTRL, 32'h0, ctrl);
        chk_word(ctrl, 32'h0);
        chk_small({3'h0, gout}, 8'h0);
        wb_write(ORC_ADDR_CTRL, 32'hFFFF_FFFF);
        wb_write(8'h0C, 32'h0);
        wb_xfer(1'h0, ORC_ADDR_CTRL, 32'h0, ctrl);
        chk_word(ctrl, 32'hFF7F_FFFF);
        wb_xfer(1'h0, 8'h0C, 32'h0, ctrl);
        chk_word(ctrl, 32'h0);
        for (int t = 0; t < 48; t++) begin
            ctrl = $urandom();
            for (int k = 0; k < 5; k++) begin
                if (t < 8) ctrl[ORC_OUT2_LSB + 3 * k +: 3] = 3'(t);
            end
            host = 5'($urandom());
            wb_write(ORC_ADDR_CTRL, ctrl);
            wb_write(ORC_ADDR_HOST, {25'h0, host, 2'h0});
            wb_xfer(1'h0, ORC_ADDR_HOST, 32'h0, rd);
            chk_word(rd, {25'h0, host, 2'h0});
            @(posedge clk_i);
            tab <= 4'($urandom());
            iclk <= 1'($urandom());
            wave <= 1'($urandom());
            repeat (3) @(posedge clk_i);
            chk_small({3'h0, gout}, {3'h0, exp_outs(ctrl, host)});
        end
        // every selector on the generated clock, four rises
        wb_write(ORC_ADDR_CTRL, 32'h0016_DB40);
        @(posedge clk_i) iclk <= 1'h0;
        repeat (3) @(posedge clk_i);
        r0 = rises;
        repeat (8) @(posedge clk_i) iclk <= ~iclk;
        repeat (3) @(posedge clk_i);
        chk_small(rises - r0, 8'h4);
        chk_small({3'h0, gout}, 8'h0);
        for (int g = 0; g < 4; g++) begin
            wb_write(ORC_ADDR_CTRL, 32'(g) << ORC_GRP_LSB);
            r0 = 8'(dma_seen);
            repeat (grp_n[g] - 1) frame();
            repeat (2) @(posedge clk_i);
            chk_small(8'(dma_seen) - r0, 8'h0);
            frame();
            repeat (2) @(posedge clk_i);
            chk_small(8'(dma_seen) - r0, 8'h1);
        end
        for (int t = 0; t < 8; t++) begin
            h = (t == 0) ? 4'h3 : 4'($urandom());
            v = (t == 0) ? 4'h3 : 4'($urandom());
            wb_write(ORC_ADDR_CTRL, {v, h, 24'h0});
            @(posedge clk_i) {le, fe, ha, va} <= 4'hF;
            @(posedge clk_i) {le, fe, ha, va} <= 4'h0;
            @(posedge clk_i);
            chk_small({h_ent, v_ent}, {h, v});
            @(posedge clk_i) {ha, va} <= 2'h3;
            @(posedge clk_i) {ha, va} <= 2'h0;
            @(posedge clk_i) le <= 1'h1;
            chk_small({h_ent, v_ent}, {h + 4'h1, v + 4'h1});
            @(posedge clk_i) le <= 1'h0;
            @(posedge clk_i);
            chk_small({h_ent, v_ent}, {h, v + 4'h1});
            wb_xfer(1'h0, ORC_ADDR_STAT, 32'h0, rd);
            chk_word(rd, {24'h0, v + 4'h1, h});
        end
        // clock enable low: strobes and frames ignored
        r0 = 8'(dma_seen);
        @(posedge clk_i) {ce, ha, va, cf} <= 4'h7;
        repeat (3) @(posedge clk_i);
        @(posedge clk_i) {ce, ha, va, cf} <= 4'h8;
        repeat (2) @(posedge clk_i);
        chk_small({h_ent, v_ent}, {h, v + 4'h1});
        chk_small(8'(dma_seen) - r0, 8'h0);
        // reset in mid-run, one edge long
        @(posedge clk_i) rst_i <= 1'h1;
        @(posedge clk_i) rst_i <= 1'h0;
        wb_xfer(1'h0, ORC_ADDR_CTRL, 32'h0, rd);
        chk_word(rd, ORC_CTRL_RST);
        chk_small({h_ent, v_ent}, {ORC_RL_RST, ORC_RL_RST});
        chk_small({3'h0, gout}, 8'h0);
        close_out();
    end
endmodule
